// ### hdl/see_top.sv
`timescale 1ns/1ps
`include "see_defines.svh"
module see_top import see_pkg::*; #(
  parameter int WR_CYCLES = `SEE_WR_CYC
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  // Two-wire bus
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  // Strap and protect pins
  input  wire logic       i_chip_select_pin,
  input  wire logic       i_unused_addr_pin_low,
  input  wire logic       i_unused_addr_pin_mid,
  input  wire logic       i_array_lock,
  // Status
  output logic            o_busy,
  output logic [9:0]      o_word_addr
);

  // ****************************************************************
  // Pin synchronisation and bus events
  // ****************************************************************
  see_pins_s pins_raw;
  see_pins_s pq;
  see_pins_s pq_d;
  logic      scl_rise;
  logic      scl_fall;
  logic      ev_start;
  logic      ev_stop;

  // Unused address pins are not routed anywhere
  assign pins_raw = '{scl: i_scl, sda: i_sda, lock: i_array_lock,
                      cs: i_chip_select_pin};

  see_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_pins    (pins_raw),
    .o_q       (pq),
    .o_q_d     (pq_d)
  );

  // Clock edges and start or stop while clock stays high
  assign scl_rise = pq.scl & ~pq_d.scl;
  assign scl_fall = ~pq.scl & pq_d.scl;
  assign ev_start = pq.scl & pq_d.scl & pq_d.sda & ~pq.sda;
  assign ev_stop  = pq.scl & pq_d.scl & ~pq_d.sda & pq.sda;

  // ****************************************************************
  // Array and page buffer
  // ****************************************************************
  see_state_s r;
  see_state_s n;
  logic       mem_we;
  logic [9:0] mem_waddr;
  logic [7:0] mem_rdata;
  logic       pb_we;
  logic [3:0] pb_waddr;
  logic [7:0] pb_rdata;
  logic [4:0] sweep_m1;
  logic       dev_match;

  see_mem #(.AW(`SEE_AW), .DW(`SEE_DW)) u_array (
    .i_clk_sys (i_clk_sys),
    .i_we      (mem_we),
    .i_waddr   (mem_waddr),
    .i_wdata   (pb_rdata),
    .i_raddr   (r.addr),
    .o_rdata   (mem_rdata)
  );

  see_mem #(.AW(`SEE_PAGE_AW), .DW(`SEE_DW)) u_page (
    .i_clk_sys (i_clk_sys),
    .i_we      (pb_we),
    .i_waddr   (pb_waddr),
    .i_wdata   (r.shreg),
    .i_raddr   (r.sweep[3:0]),
    .o_rdata   (pb_rdata)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Load a byte for transmit, drive its MSB, advance the address
  function automatic see_state_s tx_load(see_state_s s,
                                         logic [7:0] d);
    see_state_s t;
    t        = s;
    t.st     = ST_TX;
    t.cnt    = 3'h0;
    t.shreg  = d;
    t.sda_oe = ~d[7];          // Open-drain: release for one
    t.addr   = s.addr + 10'h001; // Full wrap over the array
    return t;
  endfunction : tx_load

  // Acknowledge a received byte
  function automatic see_state_s ack_byte(see_state_s s);
    see_state_s t;
    t        = s;
    t.st     = ST_ACK;
    t.sda_oe = 1'b1;
    return t;
  endfunction : ack_byte

  assign sweep_m1  = r.sweep - 5'h01;
  assign dev_match = (r.shreg[7:`SEE_DEV_TYPE_LSB] == `SEE_DEV_TYPE) &&
                     (r.shreg[`SEE_DEV_CS_BIT] == pq.cs);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    n         = r;
    mem_we    = 1'b0;
    mem_waddr = {r.addr[9:4], sweep_m1[3:0]};
    pb_we     = 1'b0;
    pb_waddr  = r.addr[3:0];
    if (r.st == ST_PROG) begin
      // Inputs ignored; copy marked buffer bytes into the page row
      n.timer = r.timer + 17'h00001;
      if (r.sweep != 5'h00 && r.sweep <= 5'h10) begin
        mem_we = r.mask[sweep_m1[3:0]];
      end
      if (r.sweep <= 5'h10) begin
        n.sweep = r.sweep + 5'h01;
      end
      if (r.timer == 17'(WR_CYCLES - 1)) begin
        n.st        = ST_IDLE;
        n.busy      = 1'b0;
        n.mask      = 16'h0000;
        n.have_data = 1'b0;
      end
    end else if (ev_start) begin
      // Any start outside programming opens a new device address byte
      n.st        = ST_RX;
      n.ph        = PH_DEV;
      n.cnt       = 3'h0;
      n.byte_done = 1'b0;
      n.sda_oe    = 1'b0;
    end else if (ev_stop) begin
      n.sda_oe = 1'b0;
      n.st     = ST_IDLE;
      if (r.ph == PH_WDATA && r.have_data) begin
        if (pq.lock) begin
          n.mask      = 16'h0000;
          n.have_data = 1'b0;
        end else begin
          n.st    = ST_PROG;
          n.busy  = 1'b1;
          n.timer = 17'h00000;
          n.sweep = 5'h00;
        end
      end
    end else begin
      unique case (r.st)
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            // Eight bits per byte, MSB first
            n.shreg = {r.shreg[6:0], pq.sda};
            n.cnt   = r.cnt + 3'h1;
            if (r.cnt == 3'h7) begin
              n.byte_done = 1'b1;
            end
          end else if (scl_fall && r.byte_done) begin
            n.byte_done = 1'b0;
            unique case (r.ph)
              PH_DEV: begin
                if (dev_match) begin
                  n         = ack_byte(n);
                  n.rw      = r.shreg[`SEE_DEV_RW_BIT];
                  n.pend_hi = r.shreg[`SEE_DEV_PAGE_LSB +: 2];
                  if (!r.shreg[`SEE_DEV_RW_BIT]) begin
                    n.ph        = PH_WADDR;
                    n.mask      = 16'h0000;
                    n.have_data = 1'b0;
                  end
                end else begin
                  n.st = ST_IDLE;
                end
              end
              PH_WADDR: begin
                n      = ack_byte(n);
                n.addr = {r.pend_hi, r.shreg};
                n.ph   = PH_WDATA;
              end
              PH_WDATA: begin
                // Buffer byte, step only the in-page bits
                n                    = ack_byte(n);
                pb_we                = 1'b1;
                n.mask[r.addr[3:0]]  = 1'b1;
                n.addr[3:0]          = r.addr[3:0] + 4'h1;
                n.have_data          = 1'b1;
              end
              default: begin
                n.st = ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK: begin
          // Ninth clock ends on its falling edge
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.cnt    = 3'h0;
            if (r.rw && r.ph == PH_DEV) begin
              n = tx_load(n, mem_rdata);
            end else begin
              n.st = ST_RX;
            end
          end
        end
        ST_TX: begin
          // New bit appears after each of the first seven falling edges; the eighth releases the line
          if (scl_fall) begin
            if (r.cnt == 3'h7) begin
              n.sda_oe = 1'b0;
              n.st     = ST_MACK;
            end else begin
              n.cnt    = r.cnt + 3'h1;
              n.shreg  = {r.shreg[6:0], 1'b0};
              n.sda_oe = ~r.shreg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            n.mack_ok = ~pq.sda;
          end else if (scl_fall) begin
            if (r.mack_ok) begin
              n = tx_load(n, mem_rdata);
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        default: begin
          n.st     = ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      r           <= '0;
      r.st        <= ST_IDLE;
      r.ph        <= PH_DEV;
      r.addr      <= `SEE_ADDR_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_sda_o     = r.sda_o;
  assign o_sda_oe    = r.sda_oe;
  assign o_busy      = r.busy;
  assign o_word_addr = r.addr;

endmodule : see_top

// ### inc/see_defines.svh
`ifndef SEE_DEFINES_SVH
`define SEE_DEFINES_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define SEE_AW          10
`define SEE_DW          8
`define SEE_PAGE_AW     4
`define SEE_ADDR_RST    10'h000

// ****************************************************************
// Device address byte fields
// ****************************************************************
`define SEE_DEV_TYPE     4'hA
`define SEE_DEV_TYPE_LSB 4
`define SEE_DEV_CS_BIT   3
`define SEE_DEV_PAGE_LSB 1
`define SEE_DEV_RW_BIT   0

// ****************************************************************
// Timing
// ****************************************************************
`define SEE_CLK_NS      50
`define SEE_T_WR_MS     5
`define SEE_WR_CYC      ((`SEE_T_WR_MS * 1000000) / `SEE_CLK_NS)
`define SEE_TMR_W       17

`endif

// ### inc/see_pkg.sv
package see_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100,
    ST_PROG = 3'b101
  } see_state_e;

  typedef enum logic [1:0] {
    PH_DEV   = 2'b00,
    PH_WADDR = 2'b01,
    PH_WDATA = 2'b10
  } see_phase_e;

  // Pin levels carried through the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic lock;
    logic cs;
  } see_pins_s;

  typedef struct packed {
    see_pins_s s1;
    see_pins_s s2;
    see_pins_s s3;
  } see_sync_s;

  // Main sequencer state
  typedef struct packed {
    see_state_e  st;
    see_phase_e  ph;
    logic [2:0]  cnt;
    logic        byte_done;
    logic [7:0]  shreg;
    logic [9:0]  addr;
    logic [1:0]  pend_hi;
    logic        rw;
    logic        mack_ok;
    logic [15:0] mask;
    logic        have_data;
    logic [4:0]  sweep;
    logic [16:0] timer;
    logic        sda_oe;
    logic        sda_o;
    logic        busy;
  } see_state_s;

endpackage : see_pkg

// ### hdl/see_mem.sv
`timescale 1ns/1ps
module see_mem #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          i_clk_sys,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Storage with registered read data
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : see_mem

// ### hdl/see_sync.sv
`timescale 1ns/1ps
module see_sync import see_pkg::*; (
  // Clock and reset
  input  wire logic      i_clk_sys,
  input  wire logic      i_resetn,
  // Raw pins
  input  see_pins_s      i_pins,
  // Synchronised level and its previous value
  output see_pins_s      o_q,
  output see_pins_s      o_q_d
);

  see_sync_s r;
  see_sync_s n;

  // Two stages for metastability, third for edge detection
  always_comb begin
    n    = r;
    n.s1 = i_pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  // Idle bus lines are high
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '1;
    end else begin
      r <= n;
    end
  end

  assign o_q   = r.s2;
  assign o_q_d = r.s3;

endmodule : see_sync

// ### sim/see_top_properties.sv
`timescale 1ns/1ps
module see_top_properties #(
  parameter int WR_CYCLES = 200
) (
  // Clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_resetn,
  // Bus and straps
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda_o,
  input wire logic       o_sda_oe,
  input wire logic       i_array_lock,
  // Status
  input wire logic       o_busy,
  input wire logic [9:0] o_word_addr
);
  int busy_cnt_r;
  int lock_cnt_r;

  // Busy length and lock-high run counters
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_cnt_r <= 0;
      lock_cnt_r <= 0;
    end else begin
      busy_cnt_r <= o_busy ? busy_cnt_r + 1 : 0;
      lock_cnt_r <= !i_array_lock ? 0 : (lock_cnt_r < 8 ? lock_cnt_r + 1 : 8);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  // ****
  // Properties
  // ****
  a_drive_low: assert property (o_sda_o == 1'b0)
    else $error("data output not low");
  a_busy_quiet: assert property (o_busy |-> !o_sda_oe)
    else $error("drives line while busy");
  a_busy_len: assert property (
    $fell(o_busy) |-> busy_cnt_r == WR_CYCLES) else $error("busy length");
  a_addr_hold: assert property (
    o_busy && $past(o_busy) |-> $stable(o_word_addr))
    else $error("address moved while busy");
  a_out_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("output changed while clock high");
  a_ack_delay: assert property (
    $rose(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
    else $error("drive not after clock fall");
  a_lock_no_prog: assert property ($rose(o_busy) |-> lock_cnt_r < 8)
    else $error("programming while locked");
  a_prog_at_stop: assert property (
    $rose(o_busy) |-> $past(i_scl, 2) && $past(i_sda, 2))
    else $error("programming without stop");
  c_prog: cover property ($rose(o_busy));
  c_done: cover property ($fell(o_busy));
  c_ack: cover property ($rose(o_sda_oe));
endmodule : see_top_properties

bind see_top see_top_properties #(.WR_CYCLES(WR_CYCLES))
  u_see_top_properties (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_array_lock(i_array_lock),
  .o_busy(o_busy), .o_word_addr(o_word_addr)
);

// ### sim/see_master.sv
`timescale 1ns/1ps
module see_master (
  // Clock and line
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  // Master drive, high means released
  output logic      o_scl,
  output logic      o_sda
);
  // Bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Step just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  // Start, also repeated start
  task automatic start();
    o_sda = 1'b1;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b0;
    tick(2);
  endtask : start
  // Stop
  task automatic stop();
    o_sda = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b1;
    tick(4);
  endtask : stop
  // Data changes only while clock low
  task automatic bit_out(input logic b);
    o_sda = b;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_scl = 1'b0;
    tick(2);
  endtask : bit_out
  // Sample late in clock high
  task automatic bit_in(output logic b);
    o_sda = 1'b1;
    tick(2);
    o_scl = 1'b1;
    tick(3);
    b = i_sda;
    tick(1);
    o_scl = 1'b0;
    tick(2);
  endtask : bit_in
  // Byte out, MSB first, then ninth clock
  task automatic send(input logic [7:0] d, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(n);
    ack = !n;
  endtask : send
  // Byte in, then acknowledge or not
  task automatic recv(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(!ack);
  endtask : recv
endmodule : see_master

// ### sim/see_top_bench.sv
`timescale 1ns/1ps
module see_top_bench;
  localparam int WR = 200;
  logic       clk, rstn, scl, m_sda, sda, cs, pin_lo, pin_mid, lock;
  logic       sda_o, sda_oe, busy;
  logic [9:0] waddr;
  int         num_errors = 0;
  int         comparisons = 0;

  // Wired-AND line with pull-up
  assign sda = m_sda & ~(sda_oe & ~sda_o);

  see_top #(.WR_CYCLES(WR)) u_see_top (
    .i_clk_sys(clk), .i_resetn(rstn), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_chip_select_pin(cs),
    .i_unused_addr_pin_low(pin_lo), .i_unused_addr_pin_mid(pin_mid),
    .i_array_lock(lock), .o_busy(busy), .o_word_addr(waddr));
  see_master u_see_master (
    .i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

  // ****
  // Helpers
  // ****
  task automatic check(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  function automatic logic [7:0] dev(logic c, logic [1:0] pg, logic rd);
    return {4'hA, c, pg, rd};
  endfunction : dev
  task automatic put(input logic [7:0] d, input logic e);
    logic a;
    u_see_master.send(d, a);
    check("ack", {9'h0, e}, {9'h0, a});
  endtask : put
  task automatic get(input logic [7:0] e, input logic ack);
    logic [7:0] d;
    u_see_master.recv(d, ack);
    check("rdata", {2'h0, e}, {2'h0, d});
  endtask : get
  task automatic load(input logic [9:0] a);
    u_see_master.start();
    put(dev(cs, a[9:8], 1'b0), 1'b1);
    put(a[7:0], 1'b1);
  endtask : load
  task automatic rd_start();
    u_see_master.start();
    put(dev(cs, 2'b00, 1'b1), 1'b1);
  endtask : rd_start
  task automatic poll(output int nacks);
    logic a;
    nacks = 0;
    for (int i = 0; i < 20; i++) begin
      u_see_master.start();
      u_see_master.send(dev(cs, 2'b00, 1'b0), a);
      u_see_master.stop();
      if (a) break;
      nacks++;
    end
    check("poll", 10'h001, {9'h0, a});
  endtask : poll

  // ****
  // Scenarios
  // ****
  task automatic t_page();
    int n;
    load(10'h00E);
    for (int i = 0; i < 16; i++) put(8'h50 + 8'(i), 1'b1);
    u_see_master.stop();
    u_see_master.tick(2);
    check("busy", 10'h001, {9'h0, busy});
    check("addr", 10'h00E, waddr);
    poll(n);
    check("nacks", 10'h001, {9'h0, n > 0});
  endtask : t_page
  task automatic t_byte();
    int n;
    load(10'h3FF);
    put(8'hC3, 1'b1);
    u_see_master.stop();
    poll(n);
    check("addr", 10'h3F0, waddr);
  endtask : t_byte
  task automatic t_seq();
    load(10'h000);
    rd_start();
    for (int k = 0; k < 16; k++) begin
      get(8'h50 + 8'((k + 2) & 15), k < 15);
    end
    check("release", 10'h000, {9'h0, sda_oe});
    u_see_master.stop();
    check("addr", 10'h010, waddr);
  endtask : t_seq
  task automatic t_wrap();
    load(10'h3FF);
    rd_start();
    get(8'hC3, 1'b1);
    get(8'h52, 1'b0);
    u_see_master.stop();
    check("addr", 10'h001, waddr);
  endtask : t_wrap
  task automatic t_cs();
    pin_lo = 1'b1;
    pin_mid = 1'b1;
    u_see_master.start();
    put(dev(~cs, 2'b00, 1'b1), 1'b0);
    u_see_master.tick(8);
    check("idle", 10'h000, {9'h0, sda_oe});
    check("sda_o", 10'h000, {9'h0, sda_o});
    cs = 1'b1;
    u_see_master.tick(4);
    load(10'h3FF);
    rd_start();
    get(8'hC3, 1'b0);
    u_see_master.stop();
    cs = 1'b0;
  endtask : t_cs
  task automatic t_lock();
    lock = 1'b1;
    load(10'h005);
    put(8'hEE, 1'b1);
    u_see_master.stop();
    u_see_master.tick(8);
    check("busy", 10'h000, {9'h0, busy});
    lock = 1'b0;
    load(10'h005);
    rd_start();
    get(8'h57, 1'b0);
    u_see_master.stop();
  endtask : t_lock

  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    cs = 1'b0;
    pin_lo = 1'b0;
    pin_mid = 1'b0;
    lock = 1'b0;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    u_see_master.tick(4);
    t_page();
    t_byte();
    t_seq();
    t_wrap();
    t_cs();
    t_lock();
    final_report();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : see_top_bench
